//--- logic/uwb_cfg.svh
`ifndef UWB_CFG_SVH
`define UWB_CFG_SVH

// Bus and word-count widths
`define UWB_DATA_W 32
`define UWB_ADDR_HI 31
`define UWB_ADDR_LO 2
`define UWB_CNT_W 16
// Word step of the address counter, in word units
`define UWB_ADDR_STEP 30'h00000001
// Reset values
`define UWB_ADDR_RST 30'h00000000
`define UWB_DATA_RST 32'h00000000
`define UWB_CNT_RST 16'h0000

`endif

//--- logic/uwb_pkg.sv
package uwb_pkg;
  // Request kinds offered by the host side
  typedef enum logic [1:0] {
    UWB_SINGLE_READ  = 2'h0,
    UWB_SINGLE_WRITE = 2'h1,
    UWB_BLOCK_READ   = 2'h2,
    UWB_BLOCK_WRITE  = 2'h3
  } uwb_req_t;

  // Gray codes along idle -> strobe -> done -> strobe; done -> idle flips both bits
  typedef enum logic [1:0] {
    UWB_IDLE = 2'b00,
    UWB_STRB = 2'b01,
    UWB_DONE = 2'b11
  } uwb_state_t;
endpackage

//--- logic/uwb_bus_if.sv
`timescale 1ns/1ns
`include "uwb_cfg.svh"
interface uwb_bus_if;
  logic stb;
  logic we;
  logic [`UWB_ADDR_HI:`UWB_ADDR_LO] adr;
  logic [`UWB_DATA_W-1:0] dat_o;
  logic [`UWB_DATA_W-1:0] dat_i;
  logic ack;
  modport master (output stb, output we, output adr, output dat_o, input dat_i, input ack);
  modport port (input stb, input we, input adr, input dat_o, output dat_i, output ack);
endinterface

//--- logic/uwb_bus_port.sv
`timescale 1ns/1ns
`include "uwb_cfg.svh"
// Maps the internal carrier onto the published bus pin names
module uwb_bus_port (
  // Internal side
  uwb_bus_if.port bus,
  // Bus pins
  output wire logic stb_o,
  output wire logic we_o,
  output wire logic [`UWB_ADDR_HI:`UWB_ADDR_LO] adr_o,
  output wire logic [`UWB_DATA_W-1:0] dat_o,
  input wire logic [`UWB_DATA_W-1:0] dat_i,
  input wire logic ack_i
);
  assign stb_o = bus.stb;
  assign we_o = bus.we;
  assign adr_o = bus.adr;
  assign dat_o = bus.dat_o;
  assign bus.dat_i = dat_i;
  assign bus.ack = ack_i;
endmodule

//--- logic/uwb_master.sv
`timescale 1ns/1ns
`include "uwb_cfg.svh"
// Behaviour
// - One bus single cycle per single request; successive cycles, split by at least one strobe-low clock, for block requests.
// - No bursts; each block word is an independent single cycle.
// - Block address steps by one word per cycle when auto-increment selected.
// - Strobe marks write enable, address and write data valid.
// - Write enable high for writes, low for reads, throughout strobe.
// - Only byte address bits 31:2 drive the bus; bits 1:0 dropped.
// - Write data leaves on a 32-bit output bus.
// - Acknowledge in the first strobe clock is accepted.
module uwb_master (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Request port
  input wire logic req_valid,
  output logic req_ready,
  input wire uwb_pkg::uwb_req_t req_kind,
  input wire logic [`UWB_DATA_W-1:0] req_byte_addr,
  input wire logic [`UWB_CNT_W-1:0] req_count,
  input wire logic req_auto_inc,
  // Write data stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [`UWB_DATA_W-1:0] wr_data,
  // Read data stream
  output logic rd_valid,
  output logic [`UWB_DATA_W-1:0] rd_data,
  // Status
  output logic busy,
  // Bus pins
  output wire logic stb_o,
  output wire logic we_o,
  output wire logic [`UWB_ADDR_HI:`UWB_ADDR_LO] adr_o,
  output wire logic [`UWB_DATA_W-1:0] dat_o,
  input wire logic [`UWB_DATA_W-1:0] dat_i,
  input wire logic ack_i
);
  ////////////////////////////////////////////////////////////////////////////
  uwb_bus_if bus ();

  uwb_bus_port u_port (
    .bus(bus),
    .stb_o(stb_o),
    .we_o(we_o),
    .adr_o(adr_o),
    .dat_o(dat_o),
    .dat_i(dat_i),
    .ack_i(ack_i)
  );

  function automatic logic is_write(input uwb_pkg::uwb_req_t k);
    is_write = (k == uwb_pkg::UWB_SINGLE_WRITE) || (k == uwb_pkg::UWB_BLOCK_WRITE);
  endfunction

  function automatic logic is_block(input uwb_pkg::uwb_req_t k);
    is_block = (k == uwb_pkg::UWB_BLOCK_READ) || (k == uwb_pkg::UWB_BLOCK_WRITE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  uwb_pkg::uwb_state_t state_ff;
  uwb_pkg::uwb_state_t nxt_state;
  logic we_ff;
  logic inc_ff;
  logic [`UWB_ADDR_HI:`UWB_ADDR_LO] adr_ff;
  logic [`UWB_DATA_W-1:0] wdat_ff;
  logic [`UWB_CNT_W-1:0] left_ff;
  logic rd_valid_ff;
  logic [`UWB_DATA_W-1:0] rd_data_ff;

  wire idle = (state_ff == uwb_pkg::UWB_IDLE);
  wire in_strb = (state_ff == uwb_pkg::UWB_STRB);
  wire in_done = (state_ff == uwb_pkg::UWB_DONE);
  wire req_write = is_write(req_kind);
  // Zero count on a block request is treated as one word
  wire [`UWB_CNT_W-1:0] req_words = (is_block(req_kind) && req_count != `UWB_CNT_RST) ?
                                    req_count : 16'h0001;
  // Write requests start only once their first word is present
  wire start = clk_en && idle && req_valid && (!req_write || wr_valid);
  wire ack_hit = clk_en && in_strb && bus.ack;
  wire last = (left_ff == 16'h0001);
  // Next word of a block waits for its write data, keeping strobe low meanwhile
  wire next_go = clk_en && in_done && !last && (!we_ff || wr_valid);
  wire load_word = start || next_go;
  wire [`UWB_ADDR_HI:`UWB_ADDR_LO] adr_step = inc_ff ? (adr_ff + `UWB_ADDR_STEP) : adr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the cycle fields
  wire [`UWB_ADDR_HI:`UWB_ADDR_LO] adr_first = req_byte_addr[`UWB_ADDR_HI:`UWB_ADDR_LO];
  // Reads load zero so dat_o shows no stale write data during a read
  wire [`UWB_DATA_W-1:0] first_wdat = req_write ? wr_data : `UWB_DATA_RST;
  wire [`UWB_DATA_W-1:0] next_wdat = we_ff ? wr_data : wdat_ff;
  wire [`UWB_CNT_W-1:0] left_dec = left_ff - 16'h0001;
  // Only read acks return data
  wire rd_take = ack_hit && !we_ff;

  ////////////////////////////////////////////////////////////////////////////
  assign req_ready = clk_en && idle && (!req_write || wr_valid);
  assign wr_ready = load_word && (start ? req_write : we_ff);
  assign busy = !idle;
  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe only while a cycle is open; no burst tags exist on this bus
  assign bus.stb = in_strb;
  assign bus.we = we_ff;
  assign bus.adr = adr_ff;
  assign bus.dat_o = wdat_ff;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      uwb_pkg::UWB_IDLE: begin
        if (start) begin
          nxt_state = uwb_pkg::UWB_STRB;
        end
      end
      uwb_pkg::UWB_STRB: begin
        if (ack_hit) begin
          nxt_state = uwb_pkg::UWB_DONE;
        end
      end
      uwb_pkg::UWB_DONE: begin
        // At least one idle clock between cycles drops strobe
        if (clk_en && last) begin
          nxt_state = uwb_pkg::UWB_IDLE;
        end else if (next_go) begin
          nxt_state = uwb_pkg::UWB_STRB;
        end
      end
      default: begin
        nxt_state = uwb_pkg::UWB_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= uwb_pkg::UWB_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle fields change only when a word is loaded, so they hold until ack
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      we_ff <= 1'b0;
    end else if (start) begin
      we_ff <= req_write;
    end
  end

  // Auto-increment only ever applies to block requests
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      inc_ff <= 1'b0;
    end else if (start) begin
      inc_ff <= req_auto_inc && is_block(req_kind);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      adr_ff <= `UWB_ADDR_RST;
    end else if (start) begin
      adr_ff <= adr_first;
    end else if (next_go) begin
      adr_ff <= adr_step;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wdat_ff <= `UWB_DATA_RST;
    end else if (start) begin
      wdat_ff <= first_wdat;
    end else if (next_go) begin
      wdat_ff <= next_wdat;
    end
  end

  // Words still to move in this request, including the open one
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      left_ff <= `UWB_CNT_RST;
    end else if (start) begin
      left_ff <= req_words;
    end else if (next_go) begin
      left_ff <= left_dec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data captured in the ack clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_valid_ff <= 1'b0;
    end else if (clk_en) begin
      rd_valid_ff <= rd_take;
    end
  end

  // rd_data holds between pulses
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_ff <= `UWB_DATA_RST;
    end else if (rd_take) begin
      rd_data_ff <= bus.dat_i;
    end
  end
endmodule

//--- verification/uwb_master_assertions.sv
`timescale 1ns/1ns
module uwb_master_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Request and streams
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [31:0] req_byte_addr,
  input wire logic rd_valid,
  input wire logic [31:0] rd_data,
  input wire logic busy,
  // Bus pins
  input wire logic stb_o,
  input wire logic we_o,
  input wire logic [31:2] adr_o,
  input wire logic [31:0] dat_o,
  input wire logic [31:0] dat_i,
  input wire logic ack_i
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_take_strobe: assert property (
    req_valid && req_ready && clk_en |=> stb_o && adr_o == $past(req_byte_addr[31:2]))
    else $error("no strobe with address after take");
  a_hold_outputs: assert property (
    stb_o && !ack_i |=> stb_o && $stable({we_o, adr_o, dat_o}))
    else $error("bus outputs moved before ack");
  a_release_strobe: assert property (
    stb_o && ack_i && clk_en |=> !stb_o)
    else $error("strobe held after ack");
  a_read_return: assert property (
    stb_o && ack_i && !we_o && clk_en |=> rd_valid && rd_data == $past(dat_i))
    else $error("read word not returned");
  a_read_pulse: assert property (
    rd_valid && clk_en |=> !rd_valid)
    else $error("read valid longer than one cycle");
  a_read_cause: assert property (
    rd_valid |-> $past(stb_o && ack_i && !we_o && clk_en) || $past(rd_valid && !clk_en))
    else $error("read valid without read ack");
  a_write_quiet: assert property (
    stb_o && we_o && ack_i && clk_en |=> !rd_valid)
    else $error("read valid after write");
  a_ready_idle: assert property (
    req_ready |-> !busy && !stb_o)
    else $error("request taken while busy");
endmodule
bind uwb_master uwb_master_assertions u_uwb_master_assertions (.*);

//--- verification/uwb_slave_model.sv
`timescale 1ns/1ns
// Memory slave; wt wait clocks, zero gives a combinational ack
module uwb_slave_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic stb_o,
  input wire logic we_o,
  input wire logic [31:2] adr_o,
  input wire logic [31:0] dat_o,
  output logic [31:0] dat_i,
  output logic ack_i,
  input wire logic [1:0] wt
);
  logic [31:0] mem [16];
  logic [1:0] cnt_ff;
  assign ack_i = stb_o && cnt_ff == wt;
  // Inverted off the ack so a stale word cannot pass
  assign dat_i = ack_i ? mem[adr_o[5:2]] : ~mem[adr_o[5:2]];
  initial for (int i = 0; i < 16; i++) mem[i] = 32'h0;
  always @(posedge sys_clk) begin
    cnt_ff <= (rst || !stb_o || ack_i) ? 2'h0 : cnt_ff + 2'h1;
    if (ack_i && we_o) mem[adr_o[5:2]] <= dat_o;
  end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  uwb_pkg::uwb_req_t req_kind = uwb_pkg::UWB_SINGLE_READ;
  logic [31:0] req_byte_addr = 32'h0;
  logic [15:0] req_count = 16'h0;
  logic req_auto_inc = 1'b0;
  logic wr_valid = 1'b0;
  logic [31:0] wr_data = 32'h0;
  logic [1:0] wt = 2'h0;
  logic req_ready, wr_ready, rd_valid, busy, stb_o, we_o, ack_i;
  logic [31:2] adr_o;
  logic [31:0] rd_data, dat_o, dat_i;
  logic [31:0] ref_mem [16];
  int mismatches = 0;
  int comparisons = 0;
  int seed = 68868;
  uwb_master u_uwb_master (.*);
  uwb_slave_model u_uwb_slave_model (.*);
  initial forever #25 sys_clk = ~sys_clk;
  initial for (int i = 0; i < 16; i++) ref_mem[i] = 32'h0;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [29:0] ea(input logic [31:0] a, input logic inc, input int x);
    return a[31:2] + (inc ? 30'(x) : 30'h0);
  endfunction
  task automatic op(input logic [1:0] k, input logic [31:0] a, input logic [15:0] n);
    int d, b, g, words;
    logic inc, tk, wtk, ce;
    logic [29:0] e;
    words = (k[1] && n != 16'h0) ? n : 1;
    inc = k[1] & 1'($random(seed));
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_kind <= uwb_pkg::uwb_req_t'(k);
    req_byte_addr <= a;
    req_count <= n;
    req_auto_inc <= inc;
    wr_valid <= k[0];
    wr_data <= $random(seed);
    wt <= 2'($random(seed));
    d = 0;
    b = 0;
    ce = 1'b0;
    for (g = 0; g < 300; g++) begin
      @(negedge sys_clk);
      if (d == words && !busy) break;
      tk = req_ready;
      wtk = wr_ready;
      if (stb_o && ack_i && clk_en) begin
        e = ea(a, inc, b);
        chk({2'h0, adr_o}, {2'h0, e});
        chk({31'h0, we_o}, {31'h0, k[0]});
        if (k[0]) chk(dat_o, ref_mem[e[3:0]]);
        b++;
      end
      e = ea(a, inc, d);
      if (wtk) ref_mem[e[3:0]] = wr_data;
      if (rd_valid && ce) chk(rd_data, ref_mem[e[3:0]]);
      if (wtk || (rd_valid && ce)) d++;
      ce = clk_en;
      @(posedge sys_clk);
      clk_en <= (($random(seed) & 32'h7) != 32'h0);
      if (tk) req_valid <= 1'b0;
      if (wtk) wr_data <= $random(seed);
      if (d == words) wr_valid <= 1'b0;
    end
    if (g == 300) begin
      mismatches++;
      stop_test();
    end else begin
      chk(32'(b), 32'(words));
    end
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) op(2'(k), 32'h00000013, 16'h0);
    op(2'h3, 32'hfffffffc, 16'h4);
    repeat (30) op(2'($random(seed)), $random(seed), 16'($random(seed)) & 16'h0007);
    stop_test();
  end
endmodule
